// ==== core/tasm_params.svh ====
// Offsets, field positions, reset values and counts of the alarm status and mask registers
`ifndef TASM_PARAMS_SVH
`define TASM_PARAMS_SVH

// Command byte addresses
`define TASM_CMD_TRIP_MASK 8'h43
`define TASM_CMD_WARN_STAT 8'h44
`define TASM_CMD_TRIP_STAT 8'h45
`define TASM_CMD_FAULT_STAT 8'h46

// Reset values
`define TASM_RST_TRIP_MASK 8'h00
`define TASM_RST_WARN_STAT 8'h00
`define TASM_RST_TRIP_STAT 8'h00
`define TASM_RST_FAULT_STAT 8'h00

// Writable and defined bits
`define TASM_TRIP_MASK_WMASK 8'h09
`define TASM_WARN_DEFINED 8'h4F
`define TASM_TRIP_DEFINED 8'h09
`define TASM_FAULT_UNUSED 8'h60

// Field positions
`define TASM_BIT_CH1 0
`define TASM_BIT_CH2 1
`define TASM_BIT_CH3 2
`define TASM_BIT_CH4 3
`define TASM_BIT_LOCAL 6
`define TASM_BIT_FAULT_CH1 1
`define TASM_BIT_FAULT_UNUSED_LO 5
`define TASM_BIT_FAULT_UNUSED_HI 6

// Trip hysteresis in degrees, one count per degree
`define TASM_TRIP_HYST 9'h004

`endif

// ==== core/tasm_pkg.sv ====
// Types shared by the alarm status and mask register logic
`default_nettype none

package tasm_pkg;

    typedef logic [7:0] tasm_byte_t;

    typedef enum logic [3:0]
    {
        TASM_SEL_MASK = 4'h1,
        TASM_SEL_WARN = 4'h2,
        TASM_SEL_TRIP = 4'h4,
        TASM_SEL_FAULT = 4'h8
    } tasm_sel_e;

endpackage

`default_nettype wire

// ==== core/tasm_trip_chan.sv ====
// Over-limit compare with hysteresis for one thermal-trip channel
`default_nettype none
`include "tasm_params.svh"

module tasm_trip_chan
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Conversion result
    input wire logic i_conv_done,
    input wire tasm_pkg::tasm_byte_t i_temp,
    input wire tasm_pkg::tasm_byte_t i_limit,
    // Status
    output logic o_over,
    output logic o_fault
);

    logic [8:0] temp_plus_hyst;
    logic clear_ok;

    assign o_over = i_temp > i_limit;
    // Fault clears only once temp is a full hysteresis below the limit (see [RQ18])
    assign temp_plus_hyst = {1'b0, i_temp} + `TASM_TRIP_HYST;
    assign clear_ok = temp_plus_hyst <= {1'b0, i_limit};

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            o_fault <= 1'b0;
        else if (i_conv_done && o_over)
            o_fault <= 1'b1;
        else if (i_conv_done && clear_ok)
            o_fault <= 1'b0; // see [RQ18]
    end

endmodule

`default_nettype wire

// ==== core/tasm_sticky8.sv ====
// Eight sticky flags, a set in the same cycle as a clear wins
`default_nettype none

module tasm_sticky8
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Events
    input wire tasm_pkg::tasm_byte_t i_set,
    input wire logic i_clear,
    // Flags
    output tasm_pkg::tasm_byte_t o_flags
);

    tasm_pkg::tasm_byte_t next_flags;

    assign next_flags = (i_clear ? 8'h00 : o_flags) | i_set;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            o_flags <= 8'h00;
        else
            o_flags <= next_flags;
    end

endmodule

`default_nettype wire

// ==== core/tasm_alarm_regs.sv ====
// Alarm status, trip mask and sensor fault registers with warning and trip outputs
//
// Behaviour
// [RQ1] Mask bit 3 blocks channel 4 trip output
// [RQ2] Mask bit 0 blocks channel 1 trip output
// [RQ3] Warning bit 6 set on local over-limit
// [RQ4] Warning bit 3 set on channel 4 over-limit
// [RQ5] Warning bit 2 set on channel 3 over-limit
// [RQ6] Warning bit 1 set on channel 2 over-limit
// [RQ7] Warning bit 0 set on channel 1 over-limit
// [RQ8] Trip bit 3 set on channel 4 over-trip
// [RQ9] Trip bit 0 set on channel 1 over-trip
// [RQ10] Fault bits 6,5 read 0 after reset, then 1
// [RQ11] Fault bit 4 flags channel 4 sense fault
// [RQ12] Fault bit 3 flags channel 3 sense fault
// [RQ13] Fault bit 2 flags channel 2 sense fault
// [RQ14] Fault bit 1 flags channel 1 sense fault
// [RQ15] Read clears warnings; persisting faults reset next conversion
// [RQ16] Warning output cleared by read or alert response
// [RQ17] Trip status read clears flags, not trip output
// [RQ18] Trip fault ends with 4 degree hysteresis
// [RQ19] Reserved bits read zero, writes ignored
// [RQ20] Masked channels still record their status flags
`default_nettype none
`include "tasm_params.svh"

module tasm_alarm_regs
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Register access from the serial engine
    input wire tasm_pkg::tasm_byte_t i_reg_cmd,
    input wire logic i_reg_wr,
    input wire tasm_pkg::tasm_byte_t i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic i_ara_done,
    output tasm_pkg::tasm_byte_t o_reg_rdata,
    output logic o_reg_hit,
    // Conversion results
    input wire logic i_conv_done,
    input wire tasm_pkg::tasm_byte_t i_local_temp,
    input wire tasm_pkg::tasm_byte_t i_ch1_temp,
    input wire tasm_pkg::tasm_byte_t i_ch2_temp,
    input wire tasm_pkg::tasm_byte_t i_ch3_temp,
    input wire tasm_pkg::tasm_byte_t i_ch4_temp,
    // Limits and warning masks
    input wire tasm_pkg::tasm_byte_t i_local_warn_lim,
    input wire tasm_pkg::tasm_byte_t i_ch1_warn_lim,
    input wire tasm_pkg::tasm_byte_t i_ch2_warn_lim,
    input wire tasm_pkg::tasm_byte_t i_ch3_warn_lim,
    input wire tasm_pkg::tasm_byte_t i_ch4_warn_lim,
    input wire tasm_pkg::tasm_byte_t i_ch1_trip_lim,
    input wire tasm_pkg::tasm_byte_t i_ch4_trip_lim,
    input wire tasm_pkg::tasm_byte_t i_warn_mask,
    // Sense fault detection, bit 0 is channel 1
    input wire logic [3:0] i_sense_fault,
    // Alarm outputs
    output logic o_thermal_trip_out,
    output logic o_trip_pin_oe_n,
    output logic o_warn_out,
    output logic o_warn_pin_oe_n,
    output logic o_trip_mask_ch1,
    output logic o_trip_mask_ch4
);

    function automatic logic above(input tasm_pkg::tasm_byte_t temp,
                                   input tasm_pkg::tasm_byte_t lim);
        above = temp > lim;
    endfunction

    tasm_pkg::tasm_byte_t trip_mask_config;
    tasm_pkg::tasm_byte_t warning_status;
    tasm_pkg::tasm_byte_t trip_status;
    tasm_pkg::tasm_byte_t sensor_fault_status;
    logic unused_hi;
    logic ch1_over;
    logic ch4_over;
    logic ch1_fault;
    logic ch4_fault;

    // Decode
    tasm_pkg::tasm_sel_e sel;
    logic sel_hit;
    logic wr_mask;
    logic rd_warn;
    logic rd_trip;
    logic warn_clear;
    tasm_pkg::tasm_byte_t warn_over;
    tasm_pkg::tasm_byte_t warn_set;
    tasm_pkg::tasm_byte_t trip_set;
    tasm_pkg::tasm_byte_t fault_val;
    tasm_pkg::tasm_byte_t next_rdata;
    logic warn_raise;
    logic next_warn;
    logic next_trip;
    logic ch1_trip_flag;
    logic ch4_trip_flag;

    assign sel = (i_reg_cmd == `TASM_CMD_TRIP_MASK) ? tasm_pkg::TASM_SEL_MASK :
                 (i_reg_cmd == `TASM_CMD_WARN_STAT) ? tasm_pkg::TASM_SEL_WARN :
                 (i_reg_cmd == `TASM_CMD_TRIP_STAT) ? tasm_pkg::TASM_SEL_TRIP :
                 tasm_pkg::TASM_SEL_FAULT;
    assign sel_hit = (i_reg_cmd == `TASM_CMD_TRIP_MASK) ||
                     (i_reg_cmd == `TASM_CMD_WARN_STAT) ||
                     (i_reg_cmd == `TASM_CMD_TRIP_STAT) ||
                     (i_reg_cmd == `TASM_CMD_FAULT_STAT);
    assign wr_mask = i_reg_wr && sel_hit && (sel == tasm_pkg::TASM_SEL_MASK);
    assign rd_warn = i_reg_rd && sel_hit && (sel == tasm_pkg::TASM_SEL_WARN);
    assign rd_trip = i_reg_rd && sel_hit && (sel == tasm_pkg::TASM_SEL_TRIP);

    // Over-limit compares, unmasked so that flags record regardless (see [RQ20])
    assign warn_over[`TASM_BIT_CH1] = above(i_ch1_temp, i_ch1_warn_lim); // see [RQ7]
    assign warn_over[`TASM_BIT_CH2] = above(i_ch2_temp, i_ch2_warn_lim); // see [RQ6]
    assign warn_over[`TASM_BIT_CH3] = above(i_ch3_temp, i_ch3_warn_lim); // see [RQ5]
    assign warn_over[`TASM_BIT_CH4] = above(i_ch4_temp, i_ch4_warn_lim); // see [RQ4]
    assign warn_over[`TASM_BIT_LOCAL] = above(i_local_temp, i_local_warn_lim); // see [RQ3]
    assign warn_over[5:4] = 2'h0; // see [RQ19]
    assign warn_over[7] = 1'b0; // see [RQ19]
    assign warn_set = i_conv_done ? (warn_over & `TASM_WARN_DEFINED) : 8'h00;

    // Trip flags; mask bits only gate the output
    assign trip_set = {4'h0, i_conv_done && ch4_over, 2'h0, i_conv_done && ch1_over};

    tasm_trip_chan u_trip_ch1
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_conv_done(i_conv_done),
        .i_temp(i_ch1_temp),
        .i_limit(i_ch1_trip_lim),
        .o_over(ch1_over),
        .o_fault(ch1_fault)
    );

    tasm_trip_chan u_trip_ch4
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_conv_done(i_conv_done),
        .i_temp(i_ch4_temp),
        .i_limit(i_ch4_trip_lim),
        .o_over(ch4_over),
        .o_fault(ch4_fault)
    );

    // Status read clears, a same-cycle conversion set wins (see [RQ15])
    assign warn_clear = rd_warn;

    tasm_sticky8 u_warn_flags
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_set(warn_set),
        .i_clear(warn_clear),
        .o_flags(warning_status)
    );

    // Trip flags clear on read even if the fault persists (see [RQ17])
    tasm_sticky8 u_trip_flags
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_set(trip_set),
        .i_clear(rd_trip),
        .o_flags(trip_status)
    );

    assign ch1_trip_flag = trip_status[`TASM_BIT_CH1]; // see [RQ9]
    assign ch4_trip_flag = trip_status[`TASM_BIT_CH4]; // see [RQ8]

    // Sense fault and unused bits
    assign fault_val = {1'b0, unused_hi, unused_hi, i_sense_fault[3], // see [RQ11]
                        i_sense_fault[2], // see [RQ12]
                        i_sense_fault[1], // see [RQ13]
                        i_sense_fault[0], // see [RQ14]
                        1'b0};

    // Warning output: raised by an unmasked over-limit at conversion end
    assign warn_raise = i_conv_done && ((warn_over & ~i_warn_mask & `TASM_WARN_DEFINED) != 8'h00);
    // Clear by status read or alert response; a new raise wins (see [RQ16])
    assign next_warn = warn_raise || (o_warn_out && !(rd_warn || i_ara_done));

    // Trip output follows the hysteresis state, not the read-clear flags (see [RQ17])
    assign next_trip = (ch1_fault && !trip_mask_config[`TASM_BIT_CH1]) || // see [RQ2]
                       (ch4_fault && !trip_mask_config[`TASM_BIT_CH4]); // see [RQ1]

    // Read data is captured before the clear takes effect
    assign next_rdata = !sel_hit ? 8'h00 :
                        (sel == tasm_pkg::TASM_SEL_MASK) ? trip_mask_config :
                        (sel == tasm_pkg::TASM_SEL_WARN) ? warning_status :
                        (sel == tasm_pkg::TASM_SEL_TRIP) ?
                        {4'h0, ch4_trip_flag, 2'h0, ch1_trip_flag} :
                        sensor_fault_status;

    // Trip mask register, reserved bits stay zero (see [RQ19])
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            trip_mask_config <= `TASM_RST_TRIP_MASK;
        else if (wr_mask)
            trip_mask_config <= i_reg_wdata & `TASM_TRIP_MASK_WMASK; // see [RQ1] see [RQ2]
    end

    // Unused fault bits go high two cycles after reset release (see [RQ10])
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            unused_hi <= 1'b0;
            sensor_fault_status <= `TASM_RST_FAULT_STAT;
        end
        else
        begin
            unused_hi <= 1'b1;
            sensor_fault_status <= fault_val;
        end
    end

    // Register read port
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_reg_rdata <= 8'h00;
            o_reg_hit <= 1'b0;
        end
        else if (i_reg_rd)
        begin
            o_reg_rdata <= next_rdata;
            o_reg_hit <= sel_hit;
        end
    end

    // Alarm outputs, open-drain enables are low while driving
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_warn_out <= 1'b0;
            o_warn_pin_oe_n <= 1'b1;
            o_thermal_trip_out <= 1'b0;
            o_trip_pin_oe_n <= 1'b1;
            o_trip_mask_ch1 <= 1'b0;
            o_trip_mask_ch4 <= 1'b0;
        end
        else
        begin
            o_warn_out <= next_warn;
            o_warn_pin_oe_n <= !next_warn;
            o_thermal_trip_out <= next_trip;
            o_trip_pin_oe_n <= !next_trip;
            o_trip_mask_ch1 <= (wr_mask ? i_reg_wdata[`TASM_BIT_CH1] :
                                trip_mask_config[`TASM_BIT_CH1]);
            o_trip_mask_ch4 <= (wr_mask ? i_reg_wdata[`TASM_BIT_CH4] :
                                trip_mask_config[`TASM_BIT_CH4]);
        end
    end

endmodule

`default_nettype wire

// ==== dv/tasm_host_model.sv ====
// Host model that issues register cycles and alert responses
`default_nettype none

module tasm_host_model
(
    // Clock
    input wire logic i_core_clk,
    // Register cycle
    output tasm_pkg::tasm_byte_t o_cmd,
    output logic o_wr,
    output tasm_pkg::tasm_byte_t o_wdata,
    output logic o_rd,
    output logic o_ara,
    input wire tasm_pkg::tasm_byte_t i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_cmd = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
        o_ara = 1'b0;
    end
    task automatic wr_reg(input tasm_pkg::tasm_byte_t c, input tasm_pkg::tasm_byte_t d);
        @(posedge i_core_clk);
        o_cmd <= c;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        // Released data shows the inverse so a stale sample cannot pass
        o_wdata <= ~d;
    endtask
    task automatic rd_reg(input tasm_pkg::tasm_byte_t c, output tasm_pkg::tasm_byte_t d);
        @(posedge i_core_clk);
        o_cmd <= c;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
    task automatic ara_pulse();
        @(posedge i_core_clk);
        o_ara <= 1'b1;
        @(posedge i_core_clk);
        o_ara <= 1'b0;
        #1;
    endtask
endmodule

`default_nettype wire

// ==== dv/tasm_alarm_regs_checker.sv ====
// Checker of the alarm register port and alarm pins
`default_nettype none
`include "tasm_params.svh"

module tasm_alarm_regs_checker
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire tasm_pkg::tasm_byte_t i_reg_cmd,
    input wire logic i_reg_wr,
    input wire tasm_pkg::tasm_byte_t i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic i_ara_done,
    input wire tasm_pkg::tasm_byte_t o_reg_rdata,
    input wire logic o_reg_hit,
    // Alarms
    input wire logic i_conv_done,
    input wire logic o_thermal_trip_out,
    input wire logic o_warn_out,
    input wire logic o_trip_mask_ch1,
    input wire logic o_trip_mask_ch4
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    wire logic rd_mask = i_reg_rd && i_reg_cmd == `TASM_CMD_TRIP_MASK;
    wire logic rd_warn = i_reg_rd && i_reg_cmd == `TASM_CMD_WARN_STAT;
    wire logic rd_miss = i_reg_rd && (i_reg_cmd < 8'h43 || i_reg_cmd > 8'h46);
    wire logic wr_mask = i_reg_wr && i_reg_cmd == `TASM_CMD_TRIP_MASK;
    tasm_pkg::tasm_byte_t wd_q;
    always_ff @(posedge i_core_clk)
    begin
        wd_q <= i_reg_wdata;
    end
    mask_write_a:
    assert property (wr_mask |=> o_trip_mask_ch1 == wd_q[0] && o_trip_mask_ch4 == wd_q[3])
    else $error("mask write");
    trip_rise_a:
    assert property ($rose(o_thermal_trip_out) |->
        !($past(o_trip_mask_ch1) && $past(o_trip_mask_ch4))) else $error("masked trip");
    trip_fall_a:
    assert property ($fell(o_thermal_trip_out) |->
        $past(i_conv_done, 2) || $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("trip fell");
    warn_rise_a:
    assert property ($rose(o_warn_out) |-> $past(i_conv_done)) else $error("warn rose");
    warn_read_a:
    assert property (rd_warn && !i_conv_done |=> !o_warn_out) else $error("warn read");
    warn_ara_a:
    assert property (i_ara_done && !i_conv_done |=> !o_warn_out) else $error("warn ara");
    miss_read_a:
    assert property (rd_miss |=> o_reg_rdata == 8'h00 && !o_reg_hit) else $error("miss read");
    mask_read_a:
    assert property (rd_mask && !i_reg_wr |=>
        o_reg_rdata == {4'h0, o_trip_mask_ch4, 2'b00, o_trip_mask_ch1}) else $error("mask read");
    warn_rsvd_a:
    assert property (rd_warn |=> (o_reg_rdata & 8'hB0) == 8'h00) else $error("warn rsvd");
    cover property (rd_warn && o_warn_out);
    cover property (i_ara_done && o_warn_out);
    cover property ($fell(o_thermal_trip_out));
endmodule

bind tasm_alarm_regs tasm_alarm_regs_checker chk_i
(
    .i_core_clk, .i_sys_rst, .i_reg_cmd, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .i_ara_done,
    .o_reg_rdata, .o_reg_hit, .i_conv_done, .o_thermal_trip_out, .o_warn_out,
    .o_trip_mask_ch1, .o_trip_mask_ch4
);

`default_nettype wire

// ==== dv/tb_thermal_alarm_status_mask_regs.sv ====
// Self-checking bench for the alarm status and mask registers
`default_nettype none
`include "tasm_params.svh"

module tb_thermal_alarm_status_mask_regs;
    timeunit 1ns;
    timeprecision 1ps;
    typedef tasm_pkg::tasm_byte_t tasm_b_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic conv = 1'b0;
    logic [3:0] sf = 4'h0;
    tasm_b_t tp[5] = '{default: 8'h00};
    tasm_b_t wl[5] = '{default: 8'hFF};
    tasm_b_t hv[3] = '{8'h65, 8'h61, 8'h60};
    tasm_b_t tl1 = 8'h64;
    tasm_b_t tl4 = 8'hFF;
    tasm_b_t wm = 8'h00;
    tasm_b_t cmd, wd, rdata, ws, ts, d, md, base, fx;
    logic wr, rd, ara, hit, trip, warn, wo, trip_oe_n, warn_oe_n;
    logic [1:0] fs, m;
    int num_errors = 0;
    int n_compared = 0;
    tasm_alarm_regs uut
    (
        .i_core_clk(clk), .i_sys_rst(rst), .i_reg_cmd(cmd), .i_reg_wr(wr), .i_reg_wdata(wd),
        .i_reg_rd(rd), .i_ara_done(ara), .o_reg_rdata(rdata), .o_reg_hit(hit),
        .i_conv_done(conv), .i_local_temp(tp[0]), .i_ch1_temp(tp[1]), .i_ch2_temp(tp[2]),
        .i_ch3_temp(tp[3]), .i_ch4_temp(tp[4]), .i_local_warn_lim(wl[0]),
        .i_ch1_warn_lim(wl[1]), .i_ch2_warn_lim(wl[2]), .i_ch3_warn_lim(wl[3]),
        .i_ch4_warn_lim(wl[4]), .i_ch1_trip_lim(tl1), .i_ch4_trip_lim(tl4),
        .i_warn_mask(wm), .i_sense_fault(sf), .o_thermal_trip_out(trip),
        .o_trip_pin_oe_n(trip_oe_n), .o_warn_out(warn), .o_warn_pin_oe_n(warn_oe_n),
        .o_trip_mask_ch1(), .o_trip_mask_ch4()
    );
    tasm_host_model host
    (
        .i_core_clk(clk), .o_cmd(cmd), .o_wr(wr), .o_wdata(wd), .o_rd(rd), .o_ara(ara),
        .i_rdata(rdata)
    );
    initial forever #5 clk = ~clk;
    task automatic chk(input tasm_b_t got, input tasm_b_t exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic hyst(input logic st, input tasm_b_t t, input tasm_b_t l);
        if (t > l)
            return 1'b1;
        return ({1'b0, t} + `TASM_TRIP_HYST <= {1'b0, l}) ? 1'b0 : st;
    endfunction
    task automatic rd_chk(input tasm_b_t c, input tasm_b_t exp);
        host.rd_reg(c, d);
        chk(d, exp);
    endtask
    task automatic do_conv();
        tasm_b_t nw;
        @(posedge clk);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        nw = {1'b0, tp[0] > wl[0], 2'b00, tp[4] > wl[4], tp[3] > wl[3], tp[2] > wl[2],
            tp[1] > wl[1]};
        ws = ws | nw;
        wo = wo | (|(nw & ~wm));
        ts = ts | {4'h0, tp[4] > tl4, 2'b00, tp[1] > tl1};
        fs = {hyst(fs[1], tp[4], tl4), hyst(fs[0], tp[1], tl1)};
        repeat (2) @(posedge clk);
        #1;
        chk_bit(warn, wo);
        chk_bit(warn_oe_n, !wo);
        chk_bit(trip, |(fs & ~m));
        chk_bit(trip_oe_n, !(|(fs & ~m)));
    endtask
    initial
    begin
        void'($urandom(32'hB263));
        {ws, ts, fs, wo, m} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // First read lands before the unused fault bits have come up
        rd_chk(`TASM_CMD_FAULT_STAT, `TASM_RST_FAULT_STAT);
        rd_chk(`TASM_CMD_TRIP_MASK, `TASM_RST_TRIP_MASK);
        rd_chk(`TASM_CMD_WARN_STAT, `TASM_RST_WARN_STAT);
        rd_chk(`TASM_CMD_TRIP_STAT, `TASM_RST_TRIP_STAT);
        rd_chk(`TASM_CMD_FAULT_STAT, `TASM_FAULT_UNUSED);
        chk_bit(hit, 1'b1);
        $display("test reset done");
        foreach (hv[i])
        begin
            @(posedge clk);
            tp[1] <= hv[i];
            do_conv();
            rd_chk(`TASM_CMD_TRIP_STAT, ts);
            ts = 8'h00;
            chk_bit(trip, fs[0]);
        end
        $display("test hysteresis done");
        for (int k = 0; k < 60; k++)
        begin
            @(posedge clk);
            base = 8'd100 + 8'($urandom % 50);
            wm <= 8'($urandom);
            sf <= 4'($urandom);
            tl1 <= base;
            tl4 <= base + 8'd2;
            foreach (wl[i])
            begin
                wl[i] <= base;
                tp[i] <= base - 8'd6 + 8'($urandom % 12);
            end
            do_conv();
            if ($urandom % 2)
            begin
                host.ara_pulse();
                chk_bit(warn, 1'b0);
            end
            rd_chk(`TASM_CMD_WARN_STAT, ws);
            ws = 8'h00;
            wo = 1'b0;
            chk_bit(warn, 1'b0);
            if ($urandom % 3 == 0)
            begin
                rd_chk(`TASM_CMD_TRIP_STAT, ts);
                ts = 8'h00;
            end
            fx = {3'b011, sf, 1'b0};
            rd_chk(`TASM_CMD_FAULT_STAT, fx);
            chk_bit(hit, 1'b1);
            md = 8'($urandom);
            host.wr_reg(`TASM_CMD_TRIP_MASK, md);
            m = {md[3], md[0]};
            host.wr_reg(8'h44 + 8'($urandom % 3), 8'hFF);
            rd_chk(`TASM_CMD_TRIP_MASK, md & `TASM_TRIP_MASK_WMASK);
            rd_chk(8'h47 + 8'($urandom % 184), 8'h00);
            chk_bit(hit, 1'b0);
        end
        $display("test random done");
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule

`default_nettype wire
